// [hdl/ddr_timing_pkg.sv]
// shared constants for the memory timing model and its controller
package ddr_timing_pkg;
    localparam int    CLK_PERIOD_NS      = 100;
    localparam int    LEVEL_FIRST_DQS_CK = 40;
    localparam int    LEVEL_DQS_DELAY_CK = 25;
    localparam real   LEVEL_OUT_MAX_NS   = 9.0;
    localparam real   LEVEL_OUT_ERR_NS   = 2.0;
    localparam int    LEVEL_OUT_CK       = (LEVEL_OUT_MAX_NS <= CLK_PERIOD_NS) ? 1 :
                                           int'($floor(LEVEL_OUT_MAX_NS / CLK_PERIOD_NS));
    localparam int    WR_REC_MIN_NS      = 15;
    localparam int    WR_REC_MIN_CK      = 4;
    localparam int    WR_REC_NS_CK       = (WR_REC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    WR_REC_CK          = (WR_REC_NS_CK > WR_REC_MIN_CK) ? WR_REC_NS_CK : WR_REC_MIN_CK;
    localparam int    WR_START_BL8       = 4;
    localparam int    WR_START_BC4_FIXED = 2;
    localparam int    RAS_MIN_NS         = 35;
    localparam int    RAS_MIN_CK         = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    DLL_LOCK_NS        = 24;
    localparam int    DLL_LOCK_MIN_CK    = 10;
    localparam int    DLL_LOCK_NS_CK     = (DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    DLL_LOCK_CK        = (DLL_LOCK_NS_CK > DLL_LOCK_MIN_CK) ? DLL_LOCK_NS_CK : DLL_LOCK_MIN_CK;
    localparam int    REFI_NS            = 7812;
    localparam int    REFI_CK            = REFI_NS / CLK_PERIOD_NS;
    localparam int    CNT_W              = 8;
    localparam int    LAT_W              = 4;
    localparam logic [LAT_W-1:0] CL_DEFAULT  = 4'h6;
    localparam logic [LAT_W-1:0] AL_DEFAULT  = 4'h0;
    localparam logic [LAT_W-1:0] CWL_DEFAULT = 4'h5;
    localparam int    DIV_HALF           = 4;
    localparam int    BANKS              = 8;
    localparam int    BANK_W             = 3;

    typedef enum logic [2:0] {
        CMD_NOP    = 3'h0,
        CMD_ACT    = 3'h1,
        CMD_RD     = 3'h2,
        CMD_WR     = 3'h3,
        CMD_REF    = 3'h4,
        CMD_MRS    = 3'h5,
        CMD_LEVEL  = 3'h6,
        CMD_ODT    = 3'h7
    } cmd_type;
endpackage

// [hdl/ddr_link_if.sv]
// link between controller and memory timing model
`timescale 1ns/1ps
interface ddr_link_if;
    import ddr_timing_pkg::*;
    logic                ck;
    logic                reset_n;
    cmd_type             cmd;
    logic [BANK_W-1:0]   bank;
    logic                auto_pre;
    logic                bc4_otf;
    logic                bc4_fixed;
    logic                dll_off;
    logic [LAT_W-1:0]    cl;
    logic [LAT_W-1:0]    al;
    logic [LAT_W-1:0]    cwl;
    logic                dqs;
    logic                dqs_oe;
    logic                dq_fb;
    logic                dq_fb_oe;
    logic                rd_strobe;
    logic                dq_oe;
    modport ctrl (output ck, reset_n, cmd, bank, auto_pre, bc4_otf, bc4_fixed, dll_off, cl, al, cwl,
                  dqs, dqs_oe, input dq_fb, dq_fb_oe, rd_strobe, dq_oe);
    modport mem  (input ck, reset_n, cmd, bank, auto_pre, bc4_otf, bc4_fixed, dll_off, cl, al, cwl,
                  dqs, dqs_oe, output dq_fb, dq_fb_oe, rd_strobe, dq_oe);
endinterface

// [hdl/ddr_mem_end.sv]
// memory end: leveling feedback, read strobe start for dll-off reads, auto precharge, write recovery
`timescale 1ns/1ps
module ddr_mem_end
    import ddr_timing_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      rst_n_i,
    ddr_link_if.mem        link,
    output logic           precharge_o,
    output logic [BANK_W-1:0] precharge_bank_o,
    output logic           wr_rec_done_o,
    output logic           leveling_o
);
    // link clock and strobe are sampled twice before use
    logic [1:0]        ck_sync_reg;
    logic [1:0]        dqs_sync_reg;
    logic              ck_prev_reg;
    logic              dqs_prev_reg;
    logic              ck_rise;
    logic              dqs_rise;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_sync_reg  <= 2'h0;
            dqs_sync_reg <= 2'h0;
            ck_prev_reg  <= 1'b0;
            dqs_prev_reg <= 1'b0;
        end else begin
            ck_sync_reg  <= {ck_sync_reg[0], link.ck};
            dqs_sync_reg <= {dqs_sync_reg[0], link.dqs & link.dqs_oe};
            ck_prev_reg  <= ck_sync_reg[1];
            dqs_prev_reg <= dqs_sync_reg[1];
        end
    end
    assign ck_rise  = ck_sync_reg[1] & ~ck_prev_reg;
    assign dqs_rise = dqs_sync_reg[1] & ~dqs_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // leveling: feedback is the sampled ck at the strobe edge
    logic leveling_reg;
    logic fb_reg;
    logic fb_oe_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            leveling_reg <= 1'b0;
        end else if (!link.reset_n) begin
            leveling_reg <= 1'b0;
        end else if (ck_rise && link.cmd == CMD_LEVEL) begin
            leveling_reg <= ~leveling_reg;
        end
    end

    // one clock of 100 ns covers the 9 ns bound, set in the edge cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fb_reg    <= 1'b0;
            fb_oe_reg <= 1'b0;
        end else begin
            fb_oe_reg <= leveling_reg & link.reset_n;
            if (leveling_reg && dqs_rise) begin
                fb_reg <= ck_sync_reg[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // commands are taken on link clock rising edges
    logic [CNT_W-1:0] ras_cnt_reg [BANKS];
    logic [BANKS-1:0] ap_pend_reg;
    logic [31:0]      rd_pipe_reg;
    logic             rd_strobe_reg;
    logic [CNT_W-1:0] wr_cnt_reg;
    logic             wr_busy_reg;
    logic             wr_done_reg;
    logic             pre_reg;
    logic [BANK_W-1:0] pre_bank_reg;
    logic [CNT_W-1:0] rd_delay;
    logic [CNT_W-1:0] wr_delay;

    assign rd_delay = (CNT_W'(link.cl) + CNT_W'(link.al) > CNT_W'(1)) ?
                      CNT_W'(link.cl) + CNT_W'(link.al) - CNT_W'(1) : CNT_W'(1);
    // recovery start, then recovery length (dll on or off alike)
    assign wr_delay = CNT_W'(link.cwl) + (link.bc4_fixed ? CNT_W'(WR_START_BC4_FIXED) : CNT_W'(WR_START_BL8))
                      + CNT_W'(WR_REC_CK);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pipe_reg   <= '0;
            rd_strobe_reg <= 1'b0;
        end else begin
            rd_strobe_reg <= 1'b0;
            if (ck_rise) begin
                // history, not a counter: back to back dll-off reads each get their strobe
                rd_pipe_reg   <= {rd_pipe_reg[30:0], link.cmd == CMD_RD && link.dll_off};
                rd_strobe_reg <= rd_pipe_reg[5'(rd_delay - CNT_W'(1))];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_cnt_reg  <= '0;
            wr_busy_reg <= 1'b0;
            wr_done_reg <= 1'b0;
        end else begin
            wr_done_reg <= 1'b0;
            if (ck_rise && link.cmd == CMD_WR) begin
                wr_cnt_reg  <= wr_delay;
                wr_busy_reg <= 1'b1;
            end else if (ck_rise && wr_busy_reg) begin
                wr_cnt_reg <= wr_cnt_reg - CNT_W'(1);
                if (wr_cnt_reg == CNT_W'(1)) begin
                    wr_busy_reg <= 1'b0;
                    wr_done_reg <= 1'b1;
                end
            end
        end
    end

    // per bank row active timers; auto precharge waits for them
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ap_pend_reg  <= '0;
            pre_reg      <= 1'b0;
            pre_bank_reg <= '0;
            for (int b = 0; b < BANKS; b++) begin
                ras_cnt_reg[b] <= '0;
            end
        end else begin
            pre_reg <= 1'b0;
            if (ck_rise) begin
                for (int b = 0; b < BANKS; b++) begin
                    if (link.cmd == CMD_ACT && link.bank == BANK_W'(b)) begin
                        ras_cnt_reg[b] <= CNT_W'(RAS_MIN_CK);
                    end else if (ras_cnt_reg[b] != '0) begin
                        ras_cnt_reg[b] <= ras_cnt_reg[b] - CNT_W'(1);
                    end
                    if ((link.cmd == CMD_RD || link.cmd == CMD_WR) && link.auto_pre && link.bank == BANK_W'(b)) begin
                        ap_pend_reg[b] <= 1'b1;
                    end else if (ap_pend_reg[b] && ras_cnt_reg[b] <= CNT_W'(1) && !pre_reg) begin
                        ap_pend_reg[b] <= 1'b0;
                        pre_reg        <= 1'b1;
                        pre_bank_reg   <= BANK_W'(b);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status outputs are plain registers; only link dq_oe and dq_fb_oe drop while reset pin is low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            precharge_o      <= 1'b0;
            precharge_bank_o <= '0;
            wr_rec_done_o    <= 1'b0;
            leveling_o       <= 1'b0;
        end else begin
            precharge_o      <= pre_reg;
            precharge_bank_o <= pre_bank_reg;
            wr_rec_done_o    <= wr_done_reg;
            leveling_o       <= leveling_reg;
        end
    end

    assign link.dq_fb     = fb_reg;
    assign link.dq_fb_oe  = fb_oe_reg;
    assign link.rd_strobe = rd_strobe_reg;
    assign link.dq_oe     = rd_strobe_reg & link.reset_n;
endmodule // ddr_mem_end

// [hdl/ddr_ctrl_end.sv]
// controller end: link clock, lock wait, leveling strobe, refresh pacing
`timescale 1ns/1ps
module ddr_ctrl_end
    import ddr_timing_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      rst_n_i,
    ddr_link_if.ctrl       link,
    input  wire logic      req_valid_i,
    input  wire cmd_type   req_cmd_i,
    input  wire logic [BANK_W-1:0] req_bank_i,
    input  wire logic      req_auto_pre_i,
    output logic           req_ready_o,
    output logic           level_fb_o
);
    logic [2:0]       div_reg;
    logic             ck_reg;
    logic             ck_rise;
    logic             mem_rst_n_reg;
    logic [CNT_W-1:0] lock_cnt_reg;
    logic [CNT_W-1:0] lvl_cnt_reg;
    logic             lvl_reg;
    logic             dqs_reg;
    logic [CNT_W-1:0] refi_cnt_reg;
    logic             ref_due_reg;
    logic [CNT_W-1:0] act_cnt_reg [BANKS];
    logic [1:0]       fb_sync_reg;
    cmd_type          cmd_reg;
    logic [BANK_W-1:0] bank_reg;
    logic             ap_reg;
    logic             ready;
    logic             lock_ok;

    // link clock made by divider; commands change on its falling edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
            ck_reg  <= 1'b0;
        end else if (div_reg == 3'(DIV_HALF - 1)) begin
            div_reg <= '0;
            ck_reg  <= ~ck_reg;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end
    assign ck_rise = (div_reg == 3'(DIV_HALF - 1)) & ck_reg; // about to fall: new command slot

    // memory reset held low from our own reset until the first command slot
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_rst_n_reg <= 1'b0;
        end else if (ck_rise) begin
            mem_rst_n_reg <= 1'b1;
        end
    end

    // lock delay counted in link clocks, restarted by mode register writes
    // mode write still on the link: its reload has not landed yet
    assign lock_ok = (lock_cnt_reg == '0) && (cmd_reg != CMD_MRS);
    assign ready   = ck_rise & mem_rst_n_reg & ~ref_due_reg & ~lvl_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt_reg <= CNT_W'(DLL_LOCK_CK);
        end else if (ck_rise) begin
            if (cmd_reg == CMD_MRS) begin
                lock_cnt_reg <= CNT_W'(DLL_LOCK_CK);
            end else if (!lock_ok) begin
                lock_cnt_reg <= lock_cnt_reg - CNT_W'(1);
            end
        end
    end

    // leveling: a single strobe after 40 clocks, then the strobe stops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_reg     <= 1'b0;
            lvl_cnt_reg <= '0;
            dqs_reg     <= 1'b0;
        end else if (ck_rise) begin
            dqs_reg <= 1'b0;
            if (cmd_reg == CMD_LEVEL && !lvl_reg) begin
                lvl_reg     <= 1'b1;
                lvl_cnt_reg <= CNT_W'(LEVEL_FIRST_DQS_CK);
            end else if (lvl_reg && lvl_cnt_reg != '0) begin
                lvl_cnt_reg <= lvl_cnt_reg - CNT_W'(1);
            end else if (lvl_reg) begin
                dqs_reg     <= 1'b1;
                lvl_reg     <= 1'b0;
            end
        end
    end

    // refresh interval is REFI_CK (rounded down) plus one clock for the reload at zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            refi_cnt_reg <= CNT_W'(REFI_CK);
            ref_due_reg  <= 1'b0;
        end else if (ck_rise) begin
            if (cmd_reg == CMD_REF) begin
                ref_due_reg <= 1'b0;
            end
            if (refi_cnt_reg == '0) begin
                refi_cnt_reg <= CNT_W'(REFI_CK);
                ref_due_reg  <= 1'b1;
            end else begin
                refi_cnt_reg <= refi_cnt_reg - CNT_W'(1);
            end
        end
    end

    // command slot: refresh first, then accepted request if the lock delay allows
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_reg  <= CMD_NOP;
            bank_reg <= '0;
            ap_reg   <= 1'b0;
            for (int b = 0; b < BANKS; b++) begin
                act_cnt_reg[b] <= '0;
            end
        end else if (ck_rise) begin
            cmd_reg <= CMD_NOP;
            ap_reg  <= 1'b0;
            for (int b = 0; b < BANKS; b++) begin
                if (act_cnt_reg[b] != '0) begin
                    act_cnt_reg[b] <= act_cnt_reg[b] - CNT_W'(1);
                end
            end
            if (mem_rst_n_reg && ref_due_reg && cmd_reg != CMD_REF) begin
                cmd_reg <= CMD_REF;
            end else if (ready && req_valid_i && req_ready_o) begin
                cmd_reg  <= req_cmd_i;
                bank_reg <= req_bank_i;
                ap_reg   <= req_auto_pre_i;
                if (req_cmd_i == CMD_ACT) begin
                    act_cnt_reg[req_bank_i] <= CNT_W'(RAS_MIN_CK);
                end
            end
        end
    end

    // ready is a flop: blocks locked commands until lock delay ends
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= mem_rst_n_reg & ~ref_due_reg & ~lvl_reg &
                           (lock_ok || !(req_cmd_i == CMD_RD || req_cmd_i == CMD_ODT));
        end
    end

    // feedback comes from the far end, synchronised
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fb_sync_reg <= 2'h0;
            level_fb_o  <= 1'b0;
        end else begin
            fb_sync_reg <= {fb_sync_reg[0], link.dq_fb & link.dq_fb_oe};
            level_fb_o  <= fb_sync_reg[1];
        end
    end

    assign link.ck        = ck_reg;
    assign link.reset_n   = mem_rst_n_reg;
    assign link.cmd       = cmd_reg;
    assign link.bank      = bank_reg;
    assign link.auto_pre  = ap_reg;
    assign link.bc4_otf   = 1'b0;
    assign link.bc4_fixed = 1'b0;
    assign link.dll_off   = 1'b1;
    assign link.cl        = CL_DEFAULT;
    assign link.al        = AL_DEFAULT;
    assign link.cwl       = CWL_DEFAULT;
    assign link.dqs       = dqs_reg;
    assign link.dqs_oe    = dqs_reg;
endmodule // ddr_ctrl_end

// [sim/ddr_link_properties.sv]
// checker of link timing between the controller end and the memory end
`timescale 1ns/1ps
module ddr_link_properties
    import ddr_timing_pkg::*;
(
    input wire logic             clock_i,
    input wire logic             rst_n_i,
    input wire logic             ck,
    input wire logic             reset_n,
    input wire cmd_type          cmd,
    input wire logic [LAT_W-1:0] cl,
    input wire logic [LAT_W-1:0] al,
    input wire logic             dqs,
    input wire logic             dq_fb,
    input wire logic             rd_strobe,
    input wire logic             dq_oe
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    logic        ck_q;
    logic        ck_rise;
    logic [7:0]  lvl_cnt;
    logic [7:0]  lock_cnt;
    logic [9:0]  ref_cnt;
    logic [15:0] rd_hist;
    assign ck_rise = ck & ~ck_q;
    // history, not a counter: reads may overlap
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_q    <= 1'b0;
            rd_hist <= 16'h0000;
        end else begin
            ck_q <= ck;
            if (ck_rise) begin
                rd_hist <= {rd_hist[14:0], cmd == CMD_RD};
            end
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_cnt <= 8'h00;
        end else if (ck_rise && cmd == CMD_LEVEL) begin
            lvl_cnt <= 8'h00;
        end else if (ck_rise && lvl_cnt != 8'hff) begin
            lvl_cnt <= lvl_cnt + 8'h01;
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt <= 8'h00;
        end else if (!reset_n || (ck_rise && cmd == CMD_MRS)) begin
            lock_cnt <= 8'h00;
        end else if (ck_rise && lock_cnt != 8'hff) begin
            lock_cnt <= lock_cnt + 8'h01;
        end
    end
    // wide enough for nine postponed refreshes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt <= 10'h000;
        end else if (!reset_n || (ck_rise && cmd == CMD_REF)) begin
            ref_cnt <= 10'h000;
        end else if (ck_rise && ref_cnt != 10'h3ff) begin
            ref_cnt <= ref_cnt + 10'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_level_wait;
        $rose(dqs) |-> lvl_cnt >= 8'(LEVEL_FIRST_DQS_CK);
    endproperty
    a_level_wait: assert property (p_level_wait) else $error("strobe too early in leveling");
    property p_level_fb;
        $rose(dqs) |-> ##3 dq_fb == $past(ck, 3);
    endproperty
    a_level_fb: assert property (p_level_fb) else $error("leveling feedback late or wrong");
    property p_rd_start;
        $rose(rd_strobe) |-> rd_hist[cl + al - 4'h1];
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read strobe not at cl+al-1");
    property p_rd_pulse;
        rd_strobe |=> !rd_strobe;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe wider than one cycle");
    property p_rd_drive;
        rd_strobe |-> dq_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("data not driven at read strobe");
    property p_lock;
        ck_rise && (cmd == CMD_RD || cmd == CMD_ODT) |-> lock_cnt >= 8'(DLL_LOCK_CK - 1);
    endproperty
    a_lock: assert property (p_lock) else $error("locked command before lock delay");
    property p_refresh;
        ck_rise |-> ref_cnt <= 10'(9 * REFI_CK);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh overdue");
    property p_link_clock;
        $changed(ck) |=> $stable(ck)[*3] ##1 $changed(ck);
    endproperty
    a_link_clock: assert property (p_link_clock) else $error("link clock period wrong");
    property p_reset_hold;
        $rose(rst_n_i) |-> !reset_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("memory reset released too soon");
endmodule // ddr_link_properties

// [sim/tb_ddr3_leveling_and_timing_rules.sv]
// self-checking bench joining the controller end and the memory end
`timescale 1ns/1ps
`define CHECK(e, g) check_val(16'(e), 16'(g))
module tb_ddr3_leveling_and_timing_rules;
    import ddr_timing_pkg::*;
    logic              clock_i        = 1'b0;
    logic              rst_n_i        = 1'b0;
    logic              req_valid_i    = 1'b0;
    cmd_type           req_cmd_i      = CMD_NOP;
    logic [BANK_W-1:0] req_bank_i     = 3'h0;
    logic              req_auto_pre_i = 1'b0;
    logic              req_ready_o;
    logic              level_fb_o;
    logic              precharge_o;
    logic [BANK_W-1:0] precharge_bank_o;
    logic              wr_rec_done_o;
    logic              leveling_o;
    logic              ck_q           = 1'b0;
    int                bad_count      = 0;
    int                cmp_count      = 0;
    int                ckn            = 0;
    int                hrun           = 0;
    int                take_ck;
    int                t0;
    logic [15:0]       q_rd[$];
    logic [15:0]       q_wr[$];
    logic [15:0]       q_pre[$];
    ddr_link_if link_if();
    ddr_mem_end i_ddr_mem_end (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_if.mem),
        .precharge_o(precharge_o), .precharge_bank_o(precharge_bank_o),
        .wr_rec_done_o(wr_rec_done_o), .leveling_o(leveling_o));
    ddr_ctrl_end i_ddr_ctrl_end (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_if.ctrl),
        .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i),
        .req_auto_pre_i(req_auto_pre_i), .req_ready_o(req_ready_o), .level_fb_o(level_fb_o));
    ddr_link_properties i_ddr_link_properties (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ck(link_if.ck), .reset_n(link_if.reset_n), .cmd(link_if.cmd), .cl(link_if.cl),
        .al(link_if.al), .dqs(link_if.dqs), .dq_fb(link_if.dq_fb),
        .rd_strobe(link_if.rd_strobe), .dq_oe(link_if.dq_oe));
    ////////////////////////////////////////////////////////////////////////////////
    always #50 clock_i = ~clock_i;
    // link clock rises and length of the high phase
    always @(posedge clock_i) begin
        ck_q <= link_if.ck;
        hrun <= (link_if.ck === 1'b1) ? hrun + 1 : 0;
        if (link_if.ck === 1'b1 && ck_q === 1'b0) ckn <= ckn + 1;
    end
    task automatic check_val(input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 16'hffff;
    endfunction
    // taken only on the last high cycle of the link clock
    task automatic send(input cmd_type c, input logic [2:0] b, input logic ap);
        int n;
        n = 0;
        @(posedge clock_i);
        req_valid_i    <= 1'b1;
        req_cmd_i      <= c;
        req_bank_i     <= b;
        req_auto_pre_i <= ap;
        do begin
            @(posedge clock_i);
            n++;
        end while (!(req_ready_o === 1'b1 && link_if.ck === 1'b1 && hrun == 3) && n < 3000);
        if (n >= 3000) bad_count++;
        take_ck = ckn;
        req_valid_i <= 1'b0;
        if (c == CMD_RD) q_rd.push_back({4'h3, 12'(take_ck + CL_DEFAULT + AL_DEFAULT)});
        if (c == CMD_WR) q_wr.push_back({4'h2, 12'(take_ck + 1 + CWL_DEFAULT + WR_START_BL8 + WR_REC_CK)});
        if ((c == CMD_RD || c == CMD_WR) && ap) q_pre.push_back({4'h1, 9'h000, b});
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (q_rd.size() + q_wr.size() + q_pre.size() > 0 && n < 600) begin
            @(posedge clock_i);
            n++;
        end
        `CHECK(0, q_rd.size() + q_wr.size() + q_pre.size());
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        if (rst_n_i === 1'b1) begin
            if (link_if.rd_strobe === 1'b1) `CHECK(pop(q_rd), {4'h3, 12'(ckn)});
            if (wr_rec_done_o === 1'b1) `CHECK(pop(q_wr), {4'h2, 12'(ckn)});
            if (precharge_o === 1'b1) `CHECK(pop(q_pre), {4'h1, 9'h000, precharge_bank_o});
        end
    end
    // run needs about 2000 cycles, so 40000 only trips on a hang
    initial begin
        #(100 * 40000);
        bad_count++;
        summarize();
    end
    initial begin
        int n;
        logic [2:0] b;
        void'($urandom(63));
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        `CHECK(1, link_if.dll_off);
        `CHECK(1, REFI_CK * CLK_PERIOD_NS <= REFI_NS);
        q_rd.delete();
        for (int k = 0; k < 2; k++) begin
            send(CMD_MRS, 3'h0, 1'b0);
            t0 = take_ck;
            send((k == 0) ? CMD_RD : CMD_ODT, 3'h0, 1'b0);
            `CHECK(1, take_ck - t0 >= DLL_LOCK_CK);
        end
        drain();
        // overlapping reads then a write on one bank
        send(CMD_ACT, 3'h5, 1'b0);
        send(CMD_RD, 3'h5, 1'b1);
        send(CMD_RD, 3'h5, 1'b0);
        send(CMD_WR, 3'h5, 1'b1);
        drain();
        repeat (10) begin
            b = 3'($urandom % 8);
            send(CMD_ACT, b, 1'b0);
            send(($urandom % 2) ? CMD_RD : CMD_WR, b, 1'($urandom % 2));
            drain();
        end
        send(CMD_LEVEL, 3'h0, 1'b0);
        repeat (40) @(posedge clock_i);
        `CHECK(1, leveling_o);
        repeat (8 * (LEVEL_FIRST_DQS_CK + 4)) @(posedge clock_i);
        `CHECK(0, level_fb_o);
        send(CMD_LEVEL, 3'h0, 1'b0);
        repeat (40) @(posedge clock_i);
        `CHECK(0, leveling_o);
        summarize();
    end
endmodule // tb_ddr3_leveling_and_timing_rules
